// *** src/swt_sleep_wake_timer.sv ***
// Purpose: Sleep wake timer with periodic wake event and byte-wide count read
// Assumes: Slow crystal arrives on a pin; RC source derived from a reference enable
// Notes: All logic on clk; slow edges become one-cycle ticks
`timescale 1ns/100ps

// Overview of operation
// [RQ1] 31-bit up-counter, resolution picks 16-bit slice
// [RQ2] Clocked by 32.768 kHz crystal or ref/750
// [RQ3] Runs in modes zero to two only
// [RQ4] Software avoids relying on it in active mode
// [RQ5] Interval is period times two^(5*resolution) ticks
// [RQ6] Software leaves 384 ticks before next event
// [RQ7] Software aligns updates to slow edge by polling
// [RQ8] Software writes period high byte then low
// [RQ9] Low count byte updates at resolution rate
// [RQ10] Software resets counter before lowering period
// [RQ11] Software waits two slow edges after reset
// [RQ12] Calibrate RC when crystal runs, active or PM0
// [RQ13] Each wake event sets wake event flag
// [RQ14] Mask set also raises CPU sleep flag
// [RQ15] Request only if enable set when flag rises
// [RQ16] Sleep interrupt blocked while mode select 00
// [RQ17] Low count register returns slice bits 7:0
// [RQ18] High count register returns slice bits 15:8
// [RQ19] Codes select bits 15:0, 20:5, 25:10, 30:15
// [RQ20] Counter reset bit loads four, reads zero
// [RQ21] Period held in two bytes, reset 0x876B
// [RQ22] Mask at bit 4, flag bit 0 write-zero clear
// [RQ23] Slice reaching period fires event and restarts
// [RQ24] Pin, event and reset request crossed safely
module swt_sleep_wake_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Special-function-register bus
  input wire swt_pkg::swt_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Slow clock sources
  input wire logic slow_xosc_pin,
  input wire logic ref_tick,
  input wire logic slow_src_rc,
  // Power state
  input wire logic hs_xosc_running,
  input wire logic in_low_power,
  input wire logic [1:0] power_mode_sel,
  // CPU interrupt side
  input wire logic cpu_sleep_irq_enable,
  input wire logic cpu_sleep_irq_flag_clr,
  output logic cpu_sleep_irq_flag,
  output logic sleep_irq_req,
  // Status
  output logic wake_event,
  output logic rc_cal_en
);
  import swt_pkg::*;

  swt_state_t s_q;
  swt_state_t s_d;
  logic run_ok;
  logic [30:0] cnt_inc;
  logic hit;
  logic slow_src_tick;
  logic [15:0] cur_slice;

  function automatic logic [15:0] slice_of(input logic [30:0] c, input logic [1:0] r);
    logic [30:0] sh;
    sh = c >> (SWT_RES_STEP * int'(r));
    return sh[15:0];
  endfunction

  function automatic logic below_zero(input logic [30:0] c, input logic [1:0] r);
    logic [30:0] m;
    m = (SWT_CNT_ONE << (SWT_RES_STEP * int'(r))) - SWT_CNT_ONE;
    return (c & m) == SWT_CNT_ZERO;
  endfunction

  always_comb begin
    s_d = s_q;
    // Crystal pin through two flops before any logic looks at it
    s_d.xo_s1 = slow_xosc_pin; // see [RQ24]
    s_d.xo_s2 = s_q.xo_s1;
    s_d.xo_prev = s_q.xo_s2;
    // RC source is the reference divided down
    if (ref_tick) begin
      s_d.rc_div = (s_q.rc_div == SWT_RC_DIV_LAST) ? SWT_RC_DIV_ZERO : s_q.rc_div + SWT_RC_DIV_ONE; // see [RQ2]
    end
    slow_src_tick = slow_src_rc ? (ref_tick && s_q.rc_div == SWT_RC_DIV_LAST) : (s_q.xo_s2 && !s_q.xo_prev); // see [RQ2]
    run_ok = !(in_low_power && power_mode_sel == SWT_MODE_PM3); // see [RQ3]
    s_d.tick = slow_src_tick && run_ok;
    // Counter step on each slow tick
    cnt_inc = s_q.cnt + SWT_CNT_ONE;
    hit = slice_of(cnt_inc, s_q.res) == s_q.period && below_zero(cnt_inc, s_q.res); // see [RQ5]
    s_d.wake_evt = 1'b0;
    if (s_q.tick) begin
      if (s_q.rst_pend) begin
        s_d.cnt = SWT_CNT_RESTART; // see [RQ20]
        s_d.rst_pend = 1'b0;
      end else if (hit) begin
        s_d.cnt = SWT_CNT_ZERO; // see [RQ23]
        s_d.wake_evt = 1'b1;
      end else begin
        s_d.cnt = cnt_inc; // see [RQ1]
      end
    end
    // Register writes
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        SWT_ADDR_IRQ_CTRL: begin
          s_d.mask = sfr_req.wdata[SWT_IRQ_MASK_BIT]; // see [RQ22]
          s_d.irq_rsvd5 = sfr_req.wdata[SWT_IRQ_RSVD5_BIT];
          if (!sfr_req.wdata[SWT_IRQ_FLAG_BIT]) begin
            s_d.flag = 1'b0; // see [RQ22]
          end
          if (!sfr_req.wdata[SWT_IRQ_RSVD1_BIT]) begin
            s_d.irq_rsvd1 = 1'b0;
          end
        end
        SWT_ADDR_TIMER_CTRL: begin
          s_d.res = sfr_req.wdata[SWT_CTRL_RES_LSB +: 2]; // see [RQ19]
          s_d.ctrl_rsvd = sfr_req.wdata[SWT_CTRL_RSVD_LSB +: 3];
          if (sfr_req.wdata[SWT_CTRL_RESET_BIT]) begin
            s_d.rst_pend = 1'b1; // see [RQ20]
          end
        end
        SWT_ADDR_PERIOD_LOW: begin
          s_d.period[7:0] = sfr_req.wdata; // see [RQ21]
        end
        SWT_ADDR_PERIOD_HIGH: begin
          s_d.period[15:8] = sfr_req.wdata; // see [RQ21]
        end
        default: begin
        end
      endcase
    end
    // Event flags, a set beats a same-cycle clear
    if (s_q.wake_evt) begin
      s_d.flag = 1'b1; // see [RQ13]
    end
    if (cpu_sleep_irq_flag_clr) begin
      s_d.cpu_flag = 1'b0;
    end
    s_d.irq_req = 1'b0;
    if (s_q.wake_evt && s_q.mask && power_mode_sel != SWT_MODE_PM0) begin
      s_d.cpu_flag = 1'b1; // see [RQ14] [RQ16]
      s_d.irq_req = cpu_sleep_irq_enable; // see [RQ15]
    end
    s_d.cal_en = hs_xosc_running && (!in_low_power || power_mode_sel == SWT_MODE_PM0); // see [RQ12]
    // Register reads, one cycle after the strobe
    s_d.rdata = SWT_BYTE_ZERO;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        SWT_ADDR_IRQ_CTRL: begin
          s_d.rdata = {2'b00, s_q.irq_rsvd5, s_q.mask, 2'b00, s_q.irq_rsvd1, s_q.flag};
        end
        SWT_ADDR_TIMER_CTRL: begin
          s_d.rdata = {1'b0, s_q.ctrl_rsvd, 2'b00, s_q.res}; // see [RQ20]
        end
        SWT_ADDR_PERIOD_LOW: begin
          s_d.rdata = s_q.period[7:0];
        end
        SWT_ADDR_PERIOD_HIGH: begin
          s_d.rdata = s_q.period[15:8];
        end
        SWT_ADDR_COUNT_LOW: begin
          s_d.rdata = cur_slice[7:0]; // see [RQ17] [RQ9]
        end
        SWT_ADDR_COUNT_HIGH: begin
          s_d.rdata = cur_slice[15:8]; // see [RQ18]
        end
        default: begin
          s_d.rdata = SWT_BYTE_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.period <= SWT_PERIOD_RESET; // see [RQ21]
      s_q.ctrl_rsvd <= SWT_CTRL_RSVD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cur_slice = slice_of(s_q.cnt, s_q.res); // see [RQ19]
  assign sfr_rdata = s_q.rdata;
  assign cpu_sleep_irq_flag = s_q.cpu_flag;
  assign sleep_irq_req = s_q.irq_req;
  assign wake_event = s_q.wake_evt;
  assign rc_cal_en = s_q.cal_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Software asks for a counter restart
  sequence reset_requested;
    sfr_req.wr && sfr_req.addr == SWT_ADDR_TIMER_CTRL && sfr_req.wdata[SWT_CTRL_RESET_BIT];
  endsequence

  // A pending restart meets a slow tick
  sequence restart_tick;
    s_q.tick && s_q.rst_pend;
  endsequence

  // A wake event that may reach the CPU
  sequence masked_event;
    s_q.wake_evt && s_q.mask && power_mode_sel != SWT_MODE_PM0;
  endsequence

  // Software clears the wake flag with no event in flight
  sequence flag_cleared;
    sfr_req.wr && sfr_req.addr == SWT_ADDR_IRQ_CTRL && !sfr_req.wdata[SWT_IRQ_FLAG_BIT] && !s_q.wake_evt;
  endsequence

  // Counter stepping
  counter_steps_a: assert property (s_q.tick && !s_q.rst_pend && !hit |=> s_q.cnt == $past(s_q.cnt) + SWT_CNT_ONE) // see [RQ1]
    else $error("counter did not step on tick");

  counter_holds_a: assert property (!s_q.tick && !$past(srst) |=> s_q.cnt == $past(s_q.cnt)) // see [RQ1]
    else $error("counter moved without tick");

  pm3_stop_a: assert property (in_low_power && power_mode_sel == SWT_MODE_PM3 |=> !s_q.tick) // see [RQ3]
    else $error("timer ticked in deepest mode");

  rc_div_range_a: assert property (s_q.rc_div <= SWT_RC_DIV_LAST) // see [RQ2]
    else $error("rc divider out of range");

  // Counter restart request
  reset_pending_a: assert property (reset_requested |=> s_q.rst_pend) // see [RQ20]
    else $error("counter reset request lost");

  reset_load_a: assert property (restart_tick |=> s_q.cnt == SWT_CNT_RESTART) // see [RQ20]
    else $error("counter reset did not load four");

  ctrl_read_zero_a: assert property (sfr_req.rd && sfr_req.addr == SWT_ADDR_TIMER_CTRL
    |=> !sfr_rdata[SWT_CTRL_RESET_BIT]) // see [RQ20]
    else $error("reset bit read back as one");

  // Wake event and flags
  event_restart_a: assert property (s_q.tick && !s_q.rst_pend && hit |=> s_q.wake_evt && s_q.cnt == SWT_CNT_ZERO) // see [RQ23] [RQ5]
    else $error("event did not restart counter");

  event_pulse_a: assert property (wake_event |=> !wake_event) // see [RQ23]
    else $error("wake event longer than one cycle");

  flag_set_a: assert property (s_q.wake_evt |=> s_q.flag) // see [RQ13]
    else $error("wake flag not set");

  flag_clear_a: assert property (flag_cleared |=> !s_q.flag) // see [RQ22]
    else $error("wake flag not cleared");

  mask_write_a: assert property (sfr_req.wr && sfr_req.addr == SWT_ADDR_IRQ_CTRL
    |=> s_q.mask == $past(sfr_req.wdata[SWT_IRQ_MASK_BIT])) // see [RQ22]
    else $error("mask bit not written");

  // CPU interrupt path
  cpu_flag_a: assert property (masked_event |=> cpu_sleep_irq_flag) // see [RQ14]
    else $error("cpu flag not raised");

  no_irq_unmasked_a: assert property (s_q.wake_evt && !s_q.mask |=> !sleep_irq_req) // see [RQ14]
    else $error("irq with mask clear");

  irq_block_a: assert property (power_mode_sel == SWT_MODE_PM0 |=> !sleep_irq_req) // see [RQ16]
    else $error("irq in mode 00");

  irq_enable_a: assert property (sleep_irq_req |-> $past(cpu_sleep_irq_enable) && cpu_sleep_irq_flag) // see [RQ15]
    else $error("irq without enable");

  irq_pulse_a: assert property (sleep_irq_req |=> !sleep_irq_req) // see [RQ15]
    else $error("irq longer than one cycle");

  // Register reads and writes
  count_read_a: assert property (sfr_req.rd && sfr_req.addr == SWT_ADDR_COUNT_HIGH
    |=> sfr_rdata == $past(cur_slice[15:8])) // see [RQ18] [RQ19]
    else $error("high count byte wrong");

  low_read_a: assert property (sfr_req.rd && sfr_req.addr == SWT_ADDR_COUNT_LOW
    |=> sfr_rdata == $past(cur_slice[7:0])) // see [RQ17] [RQ9]
    else $error("low count byte wrong");

  rdata_idle_a: assert property (!sfr_req.rd |=> sfr_rdata == SWT_BYTE_ZERO) // see [RQ17]
    else $error("read data not zero when idle");

  res_write_a: assert property (sfr_req.wr && sfr_req.addr == SWT_ADDR_TIMER_CTRL
    |=> s_q.res == $past(sfr_req.wdata[SWT_CTRL_RES_LSB +: 2])) // see [RQ19]
    else $error("resolution not written");

  period_hold_a: assert property (!(sfr_req.wr && (sfr_req.addr == SWT_ADDR_PERIOD_LOW
    || sfr_req.addr == SWT_ADDR_PERIOD_HIGH)) |=> s_q.period == $past(s_q.period)) // see [RQ21]
    else $error("period changed without write");

  // Calibration enable
  cal_a: assert property (hs_xosc_running && !in_low_power |=> rc_cal_en) // see [RQ12]
    else $error("calibration not enabled");

  cal_off_a: assert property (in_low_power && power_mode_sel != SWT_MODE_PM0 |=> !rc_cal_en) // see [RQ12]
    else $error("calibration in deep mode");

  cal_no_xosc_a: assert property (!hs_xosc_running |=> !rc_cal_en) // see [RQ12]
    else $error("calibration without crystal");
endmodule // swt_sleep_wake_timer

// *** shared/swt_pkg.sv ***
// Purpose: Shared constants and types of the sleep wake timer
// Assumes: 8-bit special-function-register bus, 100 MHz system clock
// Notes: Slow clock is handled as a one-cycle enable inside the clk domain
package swt_pkg;
  // Register addresses
  localparam logic [7:0] SWT_ADDR_IRQ_CTRL = 8'hA1;
  localparam logic [7:0] SWT_ADDR_TIMER_CTRL = 8'hA2;
  localparam logic [7:0] SWT_ADDR_PERIOD_LOW = 8'hA3;
  localparam logic [7:0] SWT_ADDR_PERIOD_HIGH = 8'hA4;
  localparam logic [7:0] SWT_ADDR_COUNT_LOW = 8'hA5;
  localparam logic [7:0] SWT_ADDR_COUNT_HIGH = 8'hA6;
  // Field positions
  localparam int SWT_IRQ_FLAG_BIT = 0;
  localparam int SWT_IRQ_RSVD1_BIT = 1;
  localparam int SWT_IRQ_MASK_BIT = 4;
  localparam int SWT_IRQ_RSVD5_BIT = 5;
  localparam int SWT_CTRL_RES_LSB = 0;
  localparam int SWT_CTRL_RESET_BIT = 2;
  localparam int SWT_CTRL_RSVD_LSB = 4;
  // Reset values
  localparam logic [15:0] SWT_PERIOD_RESET = 16'h876B;
  localparam logic [2:0] SWT_CTRL_RSVD_RESET = 3'h7;
  localparam logic [7:0] SWT_BYTE_ZERO = 8'h00;
  // Counter geometry and timing
  localparam int SWT_CNT_W = 31;
  localparam logic [30:0] SWT_CNT_RESTART = 31'h0000_0004;
  localparam logic [30:0] SWT_CNT_ZERO = 31'h0000_0000;
  localparam logic [30:0] SWT_CNT_ONE = 31'h0000_0001;
  localparam int SWT_RES_STEP = 5;
  localparam int SWT_RC_DIV = 750;
  localparam logic [9:0] SWT_RC_DIV_LAST = 10'(SWT_RC_DIV - 1);
  localparam logic [9:0] SWT_RC_DIV_ZERO = 10'h000;
  localparam logic [9:0] SWT_RC_DIV_ONE = 10'h001;
  localparam logic [1:0] SWT_MODE_PM0 = 2'h0;
  localparam logic [1:0] SWT_MODE_PM3 = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } swt_sfr_req_t;

  typedef struct packed {
    logic xo_s1;
    logic xo_s2;
    logic xo_prev;
    logic [9:0] rc_div;
    logic tick;
    logic [30:0] cnt;
    logic rst_pend;
    logic [1:0] res;
    logic [2:0] ctrl_rsvd;
    logic [15:0] period;
    logic mask;
    logic flag;
    logic irq_rsvd1;
    logic irq_rsvd5;
    logic cpu_flag;
    logic irq_req;
    logic wake_evt;
    logic cal_en;
    logic [7:0] rdata;
  } swt_state_t;
endpackage : swt_pkg

// *** testbench/swt_sleep_wake_timer_test.sv ***
// Purpose: Self-checking bench of the sleep wake timer
// Assumes: Crystal pin driven by hand, eight clk per slow period
// Notes: RC source and reference enable left idle except in the RC source test
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module swt_sleep_wake_timer_test;
  import swt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  swt_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic pin = 1'b0;
  logic hs = 1'b0;
  logic low = 1'b0;
  logic [1:0] mode = 2'h0;
  logic ien = 1'b0;
  logic clr = 1'b0;
  logic rtick = 1'b0;
  logic rc_sel = 1'b0;
  logic cpu_flag, irq_req, wake, cal;
  int err_count = 0;
  int num_checks = 0;
  int n_evt = 0;
  int n_irq = 0;
  int e0;
  int i0;

  always #5 clk = ~clk;

  swt_sleep_wake_timer dut (.clk(clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .slow_xosc_pin(pin), .ref_tick(rtick), .slow_src_rc(rc_sel), .hs_xosc_running(hs), .in_low_power(low),
    .power_mode_sel(mode), .cpu_sleep_irq_enable(ien), .cpu_sleep_irq_flag_clr(clr),
    .cpu_sleep_irq_flag(cpu_flag), .sleep_irq_req(irq_req), .wake_event(wake), .rc_cal_en(cal));

  // Pulse counters, sampled away from the launching edge
  always @(negedge clk) begin
    if (wake === 1'b1) n_evt++;
    if (irq_req === 1'b1) n_irq++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr_req.wr <= 1'b0;
  endtask

  // Read data is sampled the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req.rd <= 1'b0;
    #1;
    `CHK(sfr_rdata, exp)
  endtask

  // One slow period is eight clk cycles
  task automatic tick_n(input int n);
    repeat (n) begin
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_reset_vals;
    chk_rd(SWT_ADDR_IRQ_CTRL, 8'h00);
    chk_rd(SWT_ADDR_TIMER_CTRL, 8'h70);
    chk_rd(SWT_ADDR_PERIOD_LOW, 8'h6B);
    chk_rd(SWT_ADDR_PERIOD_HIGH, 8'h87);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h00);
    chk_rd(SWT_ADDR_COUNT_HIGH, 8'h00);
    chk_rd(8'hA0, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_event;
    @(posedge clk);
    mode <= 2'h1;
    low <= 1'b1;
    ien <= 1'b1;
    wr(SWT_ADDR_PERIOD_HIGH, 8'h00);
    wr(SWT_ADDR_PERIOD_LOW, 8'h03);
    wr(SWT_ADDR_IRQ_CTRL, 8'h10);
    e0 = n_evt;
    i0 = n_irq;
    tick_n(2);
    `CHK(n_evt, e0)
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h02);
    tick_n(1);
    `CHK(n_evt, e0 + 1)
    `CHK(n_irq, i0 + 1)
    `CHK(cpu_flag, 1'b1)
    chk_rd(SWT_ADDR_IRQ_CTRL, 8'h11);
    wr(SWT_ADDR_IRQ_CTRL, 8'h10);
    chk_rd(SWT_ADDR_IRQ_CTRL, 8'h10);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    `CHK(cpu_flag, 1'b0)
    $display("test event done");
  endtask

  task automatic t_blocked;
    @(posedge clk);
    mode <= 2'h0;
    i0 = n_irq;
    tick_n(3);
    `CHK(cpu_flag, 1'b0)
    chk_rd(SWT_ADDR_IRQ_CTRL, 8'h11);
    @(posedge clk);
    mode <= 2'h1;
    wr(SWT_ADDR_IRQ_CTRL, 8'h00);
    tick_n(3);
    `CHK(cpu_flag, 1'b0)
    chk_rd(SWT_ADDR_IRQ_CTRL, 8'h01);
    @(posedge clk);
    ien <= 1'b0;
    wr(SWT_ADDR_IRQ_CTRL, 8'h10);
    tick_n(3);
    `CHK(cpu_flag, 1'b1)
    `CHK(n_irq, i0)
    $display("test blocked done");
  endtask

  // Mode two entry with 384 slow periods before the event
  task automatic t_resolution;
    @(posedge clk);
    mode <= 2'h2;
    wr(SWT_ADDR_IRQ_CTRL, 8'h00);
    wr(SWT_ADDR_TIMER_CTRL, 8'h01);
    wr(SWT_ADDR_PERIOD_LOW, 8'h0C);
    e0 = n_evt;
    tick_n(383);
    `CHK(n_evt, e0)
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h0B);
    tick_n(1);
    `CHK(n_evt, e0 + 1)
    $display("test resolution done");
  endtask

  task automatic t_stop_restart;
    wr(SWT_ADDR_TIMER_CTRL, 8'h00);
    wr(SWT_ADDR_PERIOD_LOW, 8'h10);
    @(posedge clk);
    mode <= 2'h3;
    tick_n(2);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h00);
    @(posedge clk);
    mode <= 2'h1;
    tick_n(2);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h02);
    wr(SWT_ADDR_TIMER_CTRL, 8'h04);
    chk_rd(SWT_ADDR_TIMER_CTRL, 8'h00);
    tick_n(1);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h04);
    chk_rd(SWT_ADDR_COUNT_HIGH, 8'h00);
    e0 = n_evt;
    tick_n(1);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h05);
    wr(SWT_ADDR_PERIOD_LOW, 8'h06);
    tick_n(1);
    `CHK(n_evt, e0 + 1)
    $display("test stop and restart done");
  endtask

  // RC source: one tick per 750 reference enables
  task automatic t_rc;
    @(posedge clk);
    rc_sel <= 1'b1;
    rtick <= 1'b1;
    repeat (749) @(posedge clk);
    rtick <= 1'b0;
    repeat (2) @(posedge clk);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h00);
    @(posedge clk);
    rtick <= 1'b1;
    @(posedge clk);
    rtick <= 1'b0;
    repeat (3) @(posedge clk);
    chk_rd(SWT_ADDR_COUNT_LOW, 8'h01);
    rc_sel <= 1'b0;
    $display("test rc source done");
  endtask

  task automatic t_calib;
    @(posedge clk);
    hs <= 1'b1;
    low <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(cal, 1'b1)
    low <= 1'b1;
    mode <= 2'h0;
    repeat (3) @(posedge clk);
    `CHK(cal, 1'b1)
    mode <= 2'h2;
    repeat (3) @(posedge clk);
    `CHK(cal, 1'b0)
    $display("test calibration done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset_vals();
    t_event();
    t_blocked();
    t_resolution();
    t_stop_restart();
    t_rc();
    t_calib();
    close_out();
  end

  // Bound on the whole run
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule // swt_sleep_wake_timer_test
